// [hdl/pana_adv_hold.sv]
// Holds the word offered to the link partner.
// Assumes load is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pana_adv_hold #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] RESET_VAL = pana_pkg::ADV_RESET
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic load,
    input wire logic [WIDTH-1:0] stage_word,
    output logic [WIDTH-1:0] adv_word
);
    logic [WIDTH-1:0] adv_reg;

    // Staged edits stay invisible until a restart
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            adv_reg <= RESET_VAL;
        else if (load)
            adv_reg <= stage_word;
    end

    assign adv_word = adv_reg;
endmodule : pana_adv_hold
`default_nettype wire

// [hdl/pana_autoneg_adv.sv]
// Negotiation advertisement register bank behind AXI4-Lite.
// Assumes a negotiation engine reads adv_word on each restart pulse.
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pana_autoneg_adv #(
    parameter logic NEXT_PAGE = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic [15:0] adv_word,
    output logic restart_negotiation
);
    logic wr_fire, rd_fire, wr_ok, rd_ok;
    logic [7:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0] wr_strb;
    logic rf_reg;
    logic [pana_pkg::ABIL_N-1:0] abil_reg;
    logic restart_reg;
    logic [15:0] stage_word;

    pana_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wr_fire(wr_fire),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_fire(rd_fire),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // Address decode
    wire wr_is_ctrl = wr_addr == pana_pkg::CTRL_OFF;
    wire wr_is_adv = wr_addr == pana_pkg::ADV_OFF;
    wire wr_is_live = wr_addr == pana_pkg::LIVE_OFF;
    wire rd_is_ctrl = rd_addr == pana_pkg::CTRL_OFF;
    wire rd_is_adv = rd_addr == pana_pkg::ADV_OFF;
    wire rd_is_live = rd_addr == pana_pkg::LIVE_OFF;
    // Live copy is read-only; writes there get an error
    assign wr_ok = wr_is_ctrl || wr_is_adv;
    assign rd_ok = rd_is_ctrl || rd_is_adv || rd_is_live;
    wire wr_adv = wr_fire && wr_is_adv;
    wire wr_lo = wr_adv && wr_strb[0];
    wire wr_hi = wr_adv && wr_strb[1];
    wire restart_fire = wr_fire && wr_is_ctrl && wr_strb[1]
                        && wr_data[pana_pkg::RESTART_BIT];

    // Staged word as software sees it; fixed fields are wired
    assign stage_word = {NEXT_PAGE,
                         1'b0,
                         rf_reg,
                         4'h0,
                         abil_reg,
                         pana_pkg::SELECTOR};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rf_reg <= pana_pkg::ADV_RESET[pana_pkg::RF_BIT];
        else if (wr_hi)
            rf_reg <= wr_data[pana_pkg::RF_BIT];
    end

    // One flop per ability bit, each written by the byte lane that holds it
    genvar gi;
    generate
        for (gi = 0; gi < pana_pkg::ABIL_N; gi++)
        begin : g_abil
            localparam int POS = pana_pkg::ABIL_LO + gi;
            wire lane_wr = (POS >= 8) ? wr_hi : wr_lo;
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    abil_reg[gi] <= pana_pkg::ADV_RESET[POS];
                else if (lane_wr)
                    abil_reg[gi] <= wr_data[POS];
            end
        end
    endgenerate

    // Restart is self-clearing, so it always reads back as zero
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            restart_reg <= 1'b0;
        else
            restart_reg <= restart_fire;
    end
    assign restart_negotiation = restart_reg;

    pana_adv_hold #(
        .WIDTH(16),
        .RESET_VAL(pana_pkg::ADV_RESET)
    ) u_hold (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(restart_fire),
        .stage_word(stage_word),
        .adv_word(adv_word)
    );

    wire [31:0] rd_adv = {16'h0000, stage_word};
    wire [31:0] rd_live = {16'h0000, adv_word};
    assign rd_data = rd_is_adv ? rd_adv :
                     rd_is_live ? rd_live : 32'h0000_0000;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_np_readback: assert property (
        rd_fire && rd_is_adv |=> rvalid && rdata[15] == NEXT_PAGE)
        else $error("next page bit read back wrong");

    chk_rsv_zero: assert property (
        rd_fire && rd_is_adv |=>
        rdata[31:16] == 16'h0000 && !rdata[14] && rdata[12:9] == 4'h0)
        else $error("reserved bits not zero");

    chk_rf_write: assert property (
        wr_hi |=> stage_word[13] == $past(wr_data[13]))
        else $error("remote fault write lost");

    chk_abil_100f: assert property (
        wr_hi |=> stage_word[8] == $past(wr_data[8]))
        else $error("100 full ability write lost");

    chk_abil_100h: assert property (
        wr_lo |=> stage_word[7] == $past(wr_data[7]))
        else $error("100 half ability write lost");

    chk_abil_10f: assert property (
        wr_lo |=> stage_word[6] == $past(wr_data[6]))
        else $error("10 full ability write lost");

    chk_abil_10h: assert property (
        wr_lo |=> stage_word[5] == $past(wr_data[5]))
        else $error("10 half ability write lost");

    chk_adv_hold: assert property (
        !restart_fire |=> adv_word == $past(adv_word))
        else $error("advertised word moved without restart");

    chk_adv_load: assert property (
        restart_fire |=> restart_negotiation
        && adv_word == $past(stage_word) ##1 !restart_negotiation)
        else $error("restart did not load advertised word");

    chk_reset_value: assert property (
        $rose(aresetn) |-> adv_word == pana_pkg::ADV_RESET
        && stage_word == pana_pkg::ADV_RESET)
        else $error("reset value wrong");

    chk_selector_fixed: assert property (
        adv_word[4:0] == pana_pkg::SELECTOR
        && stage_word[4:0] == pana_pkg::SELECTOR)
        else $error("selector field changed");

    chk_np_live: assert property (
        restart_negotiation |-> adv_word[15] == NEXT_PAGE)
        else $error("next page bit advertised wrong");

    chk_adv_wr_ok: assert property (
        wr_adv |=> bvalid && bresp == pana_pkg::RESP_OKAY)
        else $error("advertisement write refused");

    chk_rsv_live: assert property (
        !adv_word[14]
        && adv_word[12:9] == 4'h0)
        else $error("reserved bits advertised");

    chk_rsv_rd_live: assert property (
        rd_fire && rd_is_live |=>
        rdata[31:16] == 16'h0000 && !rdata[14] && rdata[12:9] == 4'h0)
        else $error("reserved bits in live copy");

    chk_bad_wr_none: assert property (
        wr_fire && !wr_ok |=> stage_word == $past(stage_word)
        && adv_word == $past(adv_word))
        else $error("refused write changed a register");

    chk_bad_rd_err: assert property (
        rd_fire && !rd_ok |=> rvalid && rdata == 32'h0000_0000
        && rresp == pana_pkg::RESP_SLVERR)
        else $error("unmapped read not refused");

    chk_rf_hold: assert property (
        !wr_hi |=> stage_word[13] == $past(stage_word[13]))
        else $error("remote fault moved without write");

    chk_rf_readback: assert property (
        rd_fire && rd_is_adv |=> rdata[13] == $past(rf_reg))
        else $error("remote fault read back wrong");

    chk_rf_live: assert property (
        restart_fire |=> adv_word[13] == $past(rf_reg))
        else $error("remote fault not advertised");

    chk_abil_hi_hold: assert property (
        !wr_hi |=> stage_word[8] == $past(stage_word[8]))
        else $error("100 full ability moved without write");

    chk_abil_lo_hold: assert property (
        !wr_lo |=> stage_word[7:5] == $past(stage_word[7:5]))
        else $error("low abilities moved without write");

    chk_abil_readback: assert property (
        rd_fire && rd_is_adv |=> rdata[8:5] == $past(abil_reg))
        else $error("abilities read back wrong");

    chk_abil_live: assert property (
        restart_fire |=> adv_word[8:5] == $past(abil_reg))
        else $error("abilities not advertised");

    chk_ctrl_read_zero: assert property (
        rd_fire && rd_is_ctrl |=> rvalid && rdata == 32'h0000_0000
        && rresp == pana_pkg::RESP_OKAY)
        else $error("control register did not read zero");

    chk_restart_ok: assert property (
        restart_fire |=> bvalid && bresp == pana_pkg::RESP_OKAY)
        else $error("restart write refused");

    chk_restart_pulse: assert property (
        restart_negotiation |=> !restart_negotiation)
        else $error("restart pulse longer than one cycle");

    chk_adv_readback: assert property (
        rd_fire && rd_is_adv |=>
        rdata == {16'h0000, $past(stage_word)})
        else $error("staged word read back wrong");

    chk_live_readback: assert property (
        rd_fire && rd_is_live |=>
        rdata == {16'h0000, $past(adv_word)})
        else $error("live word read back wrong");

    chk_live_wr_err: assert property (
        wr_fire && wr_is_live |=> bvalid
        && bresp == pana_pkg::RESP_SLVERR && adv_word == $past(adv_word))
        else $error("write to live copy not refused");

    chk_reset_outputs: assert property (
        $rose(aresetn) |-> !restart_negotiation && !bvalid && !rvalid
        && awready && wready && arready)
        else $error("bus outputs wrong after reset");

    chk_selector_read: assert property (
        rd_fire && rd_is_adv |=> rdata[4:0] == pana_pkg::SELECTOR)
        else $error("selector read back wrong");

    chk_selector_rd_live: assert property (
        rd_fire && rd_is_live |=> rdata[4:0] == pana_pkg::SELECTOR)
        else $error("selector wrong in live copy");

    cov_adv_write: cover property (wr_adv ##[1:20] restart_fire);
    cov_clear_abil: cover property (wr_lo && !wr_data[5]);
    cov_live_read: cover property (rd_fire && rd_is_live);
    cov_bad_read: cover property (rd_fire && !rd_ok);
endmodule : pana_autoneg_adv
`default_nettype wire

// [hdl/pana_axil_slave.sv]
// AXI4-Lite slave front end with one-cycle register strobes.
// Assumes the register file answers wr_ok and rd_ok combinationally.
`timescale 1ns/1ps
`default_nettype none
module pana_axil_slave (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_fire,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic rd_fire,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    logic aw_held_reg, w_held_reg, rd_pend_reg;
    logic awready_reg, wready_reg, arready_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [7:0] awaddr_reg, araddr_reg;
    logic [31:0] wdata_reg, rdata_reg;
    logic [3:0] wstrb_reg;

    wire aw_take = awvalid && awready_reg;
    wire w_take = wvalid && wready_reg;
    wire b_done = bvalid_reg && bready;
    wire ar_take = arvalid && arready_reg;
    wire r_done = rvalid_reg && rready;

    // Address and data may arrive in either order
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign rd_fire = rd_pend_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= pana_pkg::RESP_OKAY;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held_reg <= 1'b1;
                awready_reg <= 1'b0;
                awaddr_reg <= awaddr;
            end
            if (w_take)
            begin
                w_held_reg <= 1'b1;
                wready_reg <= 1'b0;
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
            end
            if (wr_fire)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? pana_pkg::RESP_OKAY
                                   : pana_pkg::RESP_SLVERR;
            end
            // Ready only returns once the response is gone
            if (b_done)
            begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_pend_reg <= 1'b0;
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= pana_pkg::RESP_OKAY;
            araddr_reg <= 8'h00;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            if (ar_take)
            begin
                rd_pend_reg <= 1'b1;
                arready_reg <= 1'b0;
                araddr_reg <= araddr;
            end
            if (rd_fire)
            begin
                rd_pend_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_ok ? rd_data : 32'h0000_0000;
                rresp_reg <= rd_ok ? pana_pkg::RESP_OKAY
                                   : pana_pkg::RESP_SLVERR;
            end
            if (r_done)
            begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    assign wr_addr = awaddr_reg;
    assign wr_data = wdata_reg;
    assign wr_strb = wstrb_reg;
    assign rd_addr = araddr_reg;
    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
endmodule : pana_axil_slave
`default_nettype wire

// [hdl/pana_pkg.sv]
// Constants for the negotiation advertisement register bank.
// Assumes a 32-bit AXI4-Lite bus with byte addresses.
package pana_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] ADV_OFF = 8'h04;
    localparam logic [7:0] LIVE_OFF = 8'h08;
    localparam int NP_BIT = 15;
    localparam int RSV14_BIT = 14;
    localparam int RF_BIT = 13;
    localparam int RSV_HI = 12;
    localparam int RSV_LO = 9;
    localparam int ABIL_LO = 5;
    localparam int ABIL_N = 4;
    localparam int SEL_HI = 4;
    localparam int RESTART_BIT = 9;
    localparam logic [15:0] ADV_RESET = 16'h01E1;
    localparam logic [4:0] SELECTOR = 5'h01;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pana_pkg

// [tb/pana_link_partner.sv]
// Far-side model of the remote station during negotiation.
// Assumes the word is taken on each one-cycle restart pulse.
`timescale 1ns/1ps
`default_nettype none
module pana_link_partner (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] adv_word,
    input wire logic restart_negotiation,
    output logic [15:0] heard_word,
    output logic [7:0] heard_count
);
    // Only a restart hands the word across, never a plain write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            heard_word <= 16'h0000;
            heard_count <= 8'h00;
        end
        else if (restart_negotiation)
        begin
            heard_word <= adv_word;
            heard_count <= heard_count + 8'h01;
        end
    end
endmodule : pana_link_partner
`default_nettype wire

// [tb/phy_autoneg_advertisement_tb_top.sv]
// Self-checking bench for the advertisement register bank.
// Assumes the bus answers within 50 cycles; 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module phy_autoneg_advertisement_tb_top;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, restart_negotiation;
    logic [7:0] awaddr, araddr, heard_count, cnt;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [15:0] adv_word, heard_word, staged, live;
    int fails, tests_run;
    pana_autoneg_adv i_dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .adv_word(adv_word), .restart_negotiation(restart_negotiation));
    pana_link_partner i_peer (.aclk(aclk), .aresetn(aresetn),
        .adv_word(adv_word), .restart_negotiation(restart_negotiation),
        .heard_word(heard_word), .heard_count(heard_count));
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
            fails++;
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
        input logic [3:0] s, output logic [1:0] resp);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        resp = bresp;
        if (n == 50)
        begin
            fails++;
            print_verdict();
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
        output logic [1:0] resp);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        v = rdata;
        resp = rresp;
        if (n == 50)
        begin
            fails++;
            print_verdict();
        end
    endtask : rd
    // Byte lanes then the writable mask; selector forced to one
    function automatic logic [15:0] merge(logic [15:0] o, logic [31:0] v,
        logic [3:0] s);
        logic [15:0] m;
        m = {{8{s[1]}}, {8{s[0]}}};
        return (((o & ~m) | (v[15:0] & m)) & 16'h21E0) | 16'h0001;
    endfunction : merge
    task automatic restart;
        cnt = heard_count;
        wr(8'h00, 32'h0000_0200, 4'h2, r);
        check(r, 2'h0);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        live = staged;
        check(heard_count, 8'(cnt + 8'h01));
        check(heard_word, live);
        check(adv_word, live);
    endtask : restart
    task automatic reg_check;
        rd(8'h04, d, r);
        check(d, {16'h0000, staged});
        check(r, 2'h0);
        rd(8'h08, d, r);
        check(d, {16'h0000, live});
        @(negedge aclk);
        check(adv_word, live);
    endtask : reg_check
    initial
    begin
        {awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb} = '0;
        bready = 1'b1;
        rready = 1'b1;
        aresetn = 1'b0;
        fails = 0;
        tests_run = 0;
        void'($urandom(30552));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        staged = 16'h01E1;
        live = 16'h01E1;
        reg_check();
        rd(8'h00, d, r);
        check(d, 32'h0);
        repeat (8)
        begin
            d = $urandom;
            cnt = 8'($urandom);
            wr(8'h04, d, cnt[3:0], r);
            staged = merge(staged, d, cnt[3:0]);
            check(r, 2'h0);
            reg_check();
        end
        restart();
        // Drop one ability at a time, then restart
        for (int i = 5; i < 9; i++)
        begin
            d = {16'h0000, 16'h21E1 & ~(16'h0001 << i)};
            wr(8'h04, d, 4'h3, r);
            staged = merge(staged, d, 4'h3);
            reg_check();
            restart();
            check(heard_word[i], 1'b0);
        end
        // Live copy, a hole in the map and a far address all refuse
        for (int k = 0; k < 3; k++)
        begin
            cnt = (k == 0) ? 8'h08 : ((k == 1) ? 8'h0C : 8'h40);
            wr(cnt, 32'hFFFF_FFFF, 4'hF, r);
            check(r, 2'h2);
            reg_check();
        end
        rd(8'h0C, d, r);
        check(r, 2'h2);
        check(d, 32'h0);
        // Reset in mid-run must restore the default word
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        staged = 16'h01E1;
        live = 16'h01E1;
        reg_check();
        print_verdict();
    end
endmodule : phy_autoneg_advertisement_tb_top
`default_nettype wire
